// file: src/adccr_pkg.sv
// Shared constants and types of the converter control block
package adccr_pkg;

    // Register indices and byte addresses (byte address = 4 * index)
    localparam int unsigned ADDR_W = 12;
    localparam logic [7:0] IDX_CSR = 8'h70;
    localparam logic [7:0] IDX_RDH = 8'h71;
    localparam logic [7:0] IDX_RDL = 8'h72;
    localparam logic [ADDR_W-1:0] ADDR_CSR = {2'b00, IDX_CSR, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_RDH = {2'b00, IDX_RDH, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_RDL = {2'b00, IDX_RDL, 2'b00};

    // Control/status field positions
    localparam int unsigned CSR_EOC_POS = 7;
    localparam int unsigned CSR_SPEED_POS = 6;
    localparam int unsigned CSR_ON_POS = 5;
    localparam int unsigned CSR_RSVD_POS = 4;
    localparam int unsigned CSR_CH_LSB = 0;
    localparam int unsigned CH_W = 4;

    // Reset values
    localparam logic [7:0] CSR_RST = 8'h00;
    localparam logic [9:0] RESULT_RST = 10'h000;

    // Result width and converter timing, counted in converter ticks
    localparam int unsigned RES_W = 10;
    localparam int unsigned DIV_FAST = 2;
    localparam int unsigned DIV_SLOW = 4;
    localparam int unsigned SAMPLE_TICKS = 4;
    localparam int unsigned BIT_TICKS = 2;
    localparam int unsigned CONV_TICKS = SAMPLE_TICKS + RES_W * BIT_TICKS;
    localparam int unsigned MAX_CH = 16;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10
    } adccr_state_type;

endpackage : adccr_pkg

// file: src/adccr_conv_if.sv
// Link between register logic and conversion sequencer
`timescale 1ns/1ps
interface adccr_conv_if;
    logic run;
    logic restart;
    logic done;
    logic [9:0] result;

    modport ctrl_mp (output run, output restart, input done, input result);
    modport sar_mp (input run, input restart, output done, output result);
endinterface : adccr_conv_if

// file: src/adccr_clkdiv.sv
// Converter tick divider, CPU clock by two or four
`timescale 1ns/1ps
module adccr_clkdiv
(
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic run_i,
    input wire logic speed_i,
    output logic tick_o
);
    import adccr_pkg::*;

    localparam logic [1:0] LIM_FAST = 2'(DIV_FAST - 1);
    localparam logic [1:0] LIM_SLOW = 2'(DIV_SLOW - 1);

    logic [1:0] cnt_r;
    logic [1:0] lim;

    assign lim = speed_i ? LIM_FAST : LIM_SLOW;

    always_ff @(posedge clock_i)
    begin
        if (srst_i || !run_i)
        begin
            cnt_r <= 2'h0;
            tick_o <= 1'b0;
        end
        else if (cnt_r >= lim)
        begin
            cnt_r <= 2'h0;
            tick_o <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 2'h1;
            tick_o <= 1'b0;
        end
    end

    sequence fast_gap_s;
        (tick_o && run_i && speed_i) ##1 (run_i && speed_i) [*2];
    endsequence

    sequence slow_gap_s;
        (tick_o && run_i && !speed_i) ##1 (run_i && !speed_i) [*4];
    endsequence

    AST_DIV_FAST: assert property (
        @(posedge clock_i) disable iff (srst_i)
        fast_gap_s |-> tick_o && !$past(tick_o))
        else $error("fast tick period is not two cycles");

    AST_DIV_SLOW: assert property (
        @(posedge clock_i) disable iff (srst_i)
        slow_gap_s |-> tick_o && !$past(tick_o) && !$past(tick_o, 2)
            && !$past(tick_o, 3))
        else $error("slow tick period is not four cycles");

endmodule : adccr_clkdiv

// file: src/adccr_sar.sv
// Successive-approximation sequencer
`timescale 1ns/1ps
module adccr_sar
#(
    parameter int unsigned SAMPLE_N = adccr_pkg::SAMPLE_TICKS,
    parameter int unsigned BIT_N = adccr_pkg::BIT_TICKS
)
(
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic tick_i,
    input wire logic comp_i,
    adccr_conv_if.sar_mp conv,
    output logic sample_o,
    output logic [9:0] trial_o
);
    import adccr_pkg::*;

    localparam logic [4:0] SAMPLE_LAST = 5'(SAMPLE_N - 1);
    localparam logic [4:0] BIT_LAST = 5'(BIT_N - 1);
    localparam logic [5:0] TOTAL_LAST = 6'(SAMPLE_N + RES_W * BIT_N - 1);

    logic comp_s1_r;
    logic comp_s2_r;
    logic comp_s3_r;
    logic comp_q_r;
    adccr_state_type state_r;
    logic [4:0] cnt_r;
    logic [3:0] bit_r;
    logic [9:0] acc_r;
    logic decide;
    logic finish;
    logic [5:0] seen_r;

    // Comparator pin synchroniser
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            comp_s1_r <= 1'b0;
            comp_s2_r <= 1'b0;
            comp_s3_r <= 1'b0;
            comp_q_r <= 1'b0;
        end
        else
        begin
            comp_s1_r <= comp_i;
            comp_s2_r <= comp_s1_r;
            comp_s3_r <= comp_s2_r;
            if (comp_s2_r == comp_s3_r)
            begin
                comp_q_r <= comp_s3_r;
            end
        end
    end

    assign decide = conv.run && !conv.restart && tick_i
        && state_r == ST_CONVERT && cnt_r == BIT_LAST;
    assign finish = decide && bit_r == 4'h0;

    // Sequencer
    always_ff @(posedge clock_i)
    begin
        if (srst_i || !conv.run)
        begin
            state_r <= ST_IDLE;
            cnt_r <= 5'h00;
            bit_r <= 4'h9;
            acc_r <= RESULT_RST;
        end
        else if (conv.restart || state_r == ST_IDLE)
        begin
            state_r <= ST_SAMPLE;
            cnt_r <= 5'h00;
            bit_r <= 4'h9;
            acc_r <= RESULT_RST;
        end
        else if (tick_i)
        begin
            case (state_r)
                ST_SAMPLE:
                begin
                    if (cnt_r == SAMPLE_LAST)
                    begin
                        state_r <= ST_CONVERT;
                        cnt_r <= 5'h00;
                        acc_r <= 10'h200;
                    end
                    else
                    begin
                        cnt_r <= cnt_r + 5'h01;
                    end
                end
                ST_CONVERT:
                begin
                    if (cnt_r != BIT_LAST)
                    begin
                        cnt_r <= cnt_r + 5'h01;
                    end
                    else if (bit_r == 4'h0)
                    begin
                        state_r <= ST_SAMPLE;
                        cnt_r <= 5'h00;
                        bit_r <= 4'h9;
                        acc_r <= RESULT_RST;
                    end
                    else
                    begin
                        cnt_r <= 5'h00;
                        acc_r[bit_r] <= comp_q_r;
                        acc_r[bit_r - 4'h1] <= 1'b1;
                        bit_r <= bit_r - 4'h1;
                    end
                end
                default:
                begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Result capture and completion pulse
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            conv.done <= 1'b0;
            conv.result <= RESULT_RST;
        end
        else
        begin
            conv.done <= finish;
            if (finish)
            begin
                conv.result <= {acc_r[9:1], comp_q_r};
            end
        end
    end

    assign sample_o = state_r == ST_SAMPLE;
    assign trial_o = acc_r;

    // Tick count since conversion start, checked at completion
    always_ff @(posedge clock_i)
    begin
        if (srst_i || state_r == ST_IDLE || conv.restart || finish)
        begin
            seen_r <= 6'h00;
        end
        else if (tick_i)
        begin
            seen_r <= seen_r + 6'h01;
        end
    end

    AST_CONV_LEN: assert property (
        @(posedge clock_i) disable iff (srst_i)
        finish |-> seen_r == TOTAL_LAST)
        else $error("conversion length differs from set tick count");

    AST_RESTART: assert property (
        @(posedge clock_i) disable iff (srst_i)
        conv.run && conv.restart |=> state_r == ST_SAMPLE && !conv.done
            && seen_r == 6'h00)
        else $error("channel change did not restart conversion");

    AST_CONTINUOUS: assert property (
        @(posedge clock_i) disable iff (srst_i)
        conv.done |-> state_r == ST_SAMPLE)
        else $error("next conversion did not start after completion");

    AST_OFF_HALTS: assert property (
        @(posedge clock_i) disable iff (srst_i)
        !conv.run |=> state_r == ST_IDLE && !conv.done)
        else $error("conversion continued while disabled");

endmodule : adccr_sar

// file: src/adccr_top.sv
// Converter control, status and result registers on APB
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
// Overview of operation
// - Done flag sets on completion; clears on high-result read or status write.
// - Done flag is read-only; all other status bits are read/write.
// - Clock select 0 gives CPU clock over four, 1 over two.
// - Converter-on 1 enables and starts converting; 0 stops conversion.
// - Converter-on clear puts the converter in low consumption.
// - Four channel bits pick analog input 0 to 15 in binary.
// - Present input count is a build parameter; absent codes select nothing.
// - High result register returns result bits 9..2, read-only.
// - Low result register returns bits 1..0, zeros above, read-only.
// - Status, high and low registers sit at consecutive indices.
// - Reset clears all three registers.
// - Wait-for-interrupt state does not affect the converter.
// - Clock-stop state disables converter; software waits settle delay after.
// - While on, conversions repeat back to back, each setting done.
// - Channel change aborts conversion, clears done, restarts on new channel.
// - Results not latched as pair; each completion overwrites both.
module adccr_top
#(
    parameter int unsigned NUM_CH = adccr_pkg::MAX_CH,
    parameter int unsigned SAMPLE_N = adccr_pkg::SAMPLE_TICKS,
    parameter int unsigned BIT_N = adccr_pkg::BIT_TICKS
)
(
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [adccr_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic halt_i,
    input wire logic comp_i,
    output logic power_on_o,
    output logic sample_o,
    output logic [9:0] trial_o,
    output logic [NUM_CH-1:0] ain_sel_o
);
    import adccr_pkg::*;

    adccr_conv_if conv ();

    logic [6:0] ctl_r;
    logic eoc_r;
    logic [RES_W-1:0] res_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic setup;
    logic access;
    logic wr_csr;
    logic rd_rdh;
    logic [7:0] rd_val;
    logic hit;
    logic tick;
    logic [CH_W-1:0] chan;

    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i;
    assign wr_csr = access && pwrite_i && paddr_i == ADDR_CSR
        && pstrb_i[0];
    assign rd_rdh = access && !pwrite_i && paddr_i == ADDR_RDH;
    assign chan = ctl_r[CSR_CH_LSB +: CH_W];

    // Clock-stop state disables; wait state has no input here
    assign conv.run = ctl_r[CSR_ON_POS] && !halt_i;
    assign conv.restart = wr_csr
        && pwdata_i[CSR_CH_LSB +: CH_W] != chan;
    assign power_on_o = conv.run;

    // Read decode
    always_comb
    begin
        rd_val = 8'h00;
        hit = 1'b1;
        if (paddr_i == ADDR_CSR)
        begin
            rd_val = {eoc_r, ctl_r};
        end
        else if (paddr_i == ADDR_RDH)
        begin
            rd_val = res_r[9:2];
        end
        else if (paddr_i == ADDR_RDL)
        begin
            rd_val = {6'h00, res_r[1:0]};
        end
        else
        begin
            hit = 1'b0;
        end
    end

    // Control bits, done flag excluded
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            ctl_r <= CSR_RST[6:0];
        end
        else if (wr_csr)
        begin
            ctl_r <= pwdata_i[6:0];
        end
    end

    // Done flag, set wins over clear
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            eoc_r <= CSR_RST[CSR_EOC_POS];
        end
        else if (conv.done)
        begin
            eoc_r <= 1'b1;
        end
        else if (wr_csr || rd_rdh)
        begin
            eoc_r <= 1'b0;
        end
    end

    // Result store, overwritten by every completion
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            res_r <= RESULT_RST;
        end
        else if (conv.done)
        begin
            res_r <= conv.result;
        end
    end

    // Bus answer prepared in the setup cycle
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else if (setup)
        begin
            prdata_r <= {24'h00_0000, hit ? rd_val : 8'h00};
            pslverr_r <= !hit;
        end
    end

    assign prdata_o = prdata_r;
    assign pready_o = 1'b1;
    assign pslverr_o = pslverr_r && access;

    // Channel pin select, one per present input
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_sel
            assign ain_sel_o[g] = conv.run
                && chan == CH_W'(g);
        end
    endgenerate

    adccr_clkdiv u_div
    (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .run_i(conv.run),
        .speed_i(ctl_r[CSR_SPEED_POS]),
        .tick_o(tick)
    );

    adccr_sar #(.SAMPLE_N(SAMPLE_N), .BIT_N(BIT_N)) u_sar
    (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .tick_i(tick),
        .comp_i(comp_i),
        .conv(conv),
        .sample_o(sample_o),
        .trial_o(trial_o)
    );

    sequence rd_setup_s(logic [ADDR_W-1:0] a);
        psel_i && !penable_i && !pwrite_i && paddr_i == a;
    endsequence

    sequence csr_nostrb_s;
        access && pwrite_i && paddr_i == ADDR_CSR && !pstrb_i[0];
    endsequence

    AST_EOC_SET: assert property (
        @(posedge clock_i) disable iff (srst_i)
        conv.done |=> eoc_r)
        else $error("done flag not set after completion");

    AST_EOC_CLR_READ: assert property (
        @(posedge clock_i) disable iff (srst_i)
        rd_rdh && !conv.done |=> !eoc_r)
        else $error("high result read did not clear done flag");

    AST_EOC_RO: assert property (
        @(posedge clock_i) disable iff (srst_i)
        wr_csr && pwdata_i[CSR_EOC_POS] && !conv.done |=> !eoc_r)
        else $error("done flag took a written one");

    AST_CSR_RW: assert property (
        @(posedge clock_i) disable iff (srst_i)
        wr_csr ##2 rd_setup_s(ADDR_CSR) |=>
            prdata_o[6:0] == $past(pwdata_i[6:0], 3))
        else $error("status bits did not read back as written");

    AST_RDH_DATA: assert property (
        @(posedge clock_i) disable iff (srst_i)
        rd_setup_s(ADDR_RDH) |=> prdata_o == {24'h00_0000, $past(res_r[9:2])})
        else $error("high result read returns wrong bits");

    AST_RDL_DATA: assert property (
        @(posedge clock_i) disable iff (srst_i)
        rd_setup_s(ADDR_RDL) |=> prdata_o[7:2] == 6'h00
            && prdata_o[1:0] == $past(res_r[1:0]))
        else $error("low result read returns wrong bits");

    AST_OFF_POWER: assert property (
        @(posedge clock_i) disable iff (srst_i)
        wr_csr && !pwdata_i[CSR_ON_POS] |=> !power_on_o && ain_sel_o == '0)
        else $error("converter still powered after disable");

    AST_CHAN_SEL: assert property (
        @(posedge clock_i) disable iff (srst_i)
        $onehot0(ain_sel_o) && (int'(chan) < NUM_CH || ain_sel_o == '0))
        else $error("channel select drives wrong input");

    AST_CHAN_RESTART: assert property (
        @(posedge clock_i) disable iff (srst_i)
        conv.restart && !conv.done |=> !eoc_r ##1 !conv.done)
        else $error("channel change left done flag or completion");

    AST_CSR_READ: assert property (
        @(posedge clock_i) disable iff (srst_i)
        rd_setup_s(ADDR_CSR) |=>
            prdata_o == {24'h00_0000, $past(eoc_r), $past(ctl_r)})
        else $error("status read does not show flag and control bits");

    AST_STRB_GATE: assert property (
        @(posedge clock_i) disable iff (srst_i)
        csr_nostrb_s |=> $stable(ctl_r))
        else $error("status write without lane strobe changed bits");

    AST_EOC_CLR_WRITE: assert property (
        @(posedge clock_i) disable iff (srst_i)
        wr_csr && !conv.done |=> !eoc_r)
        else $error("status write did not clear done flag");

    AST_EOC_HOLD: assert property (
        @(posedge clock_i) disable iff (srst_i)
        !conv.done && !wr_csr && !rd_rdh |=> $stable(eoc_r))
        else $error("done flag changed without cause");

    AST_RES_LOAD: assert property (
        @(posedge clock_i) disable iff (srst_i)
        conv.done |=> res_r == $past(conv.result))
        else $error("completion did not overwrite result");

    AST_RES_HOLD: assert property (
        @(posedge clock_i) disable iff (srst_i)
        !conv.done |=> $stable(res_r))
        else $error("result changed without completion");

    AST_RO_WRITE: assert property (
        @(posedge clock_i) disable iff (srst_i)
        access && pwrite_i && paddr_i != ADDR_CSR |=> $stable(ctl_r))
        else $error("write outside status changed control bits");

    AST_MAP_ERR: assert property (
        @(posedge clock_i) disable iff (srst_i)
        access |-> pslverr_o == !(paddr_i == ADDR_CSR
            || paddr_i == ADDR_RDH || paddr_i == ADDR_RDL))
        else $error("error response does not match address map");

    AST_HALT_OFF: assert property (
        @(posedge clock_i) disable iff (srst_i)
        halt_i |-> !power_on_o && ain_sel_o == '0)
        else $error("converter powered during clock stop");

    AST_SEL_PICK: assert property (
        @(posedge clock_i) disable iff (srst_i)
        conv.run && int'(chan) < NUM_CH |-> ain_sel_o[chan])
        else $error("selected input pin not driven");

    AST_DONE_PULSE: assert property (
        @(posedge clock_i) disable iff (srst_i)
        conv.done |=> !conv.done)
        else $error("completion pulse longer than one cycle");

    AST_RESET_VAL: assert property (
        @(posedge clock_i)
        srst_i |=> !eoc_r && ctl_r == CSR_RST[6:0] && res_r == RESULT_RST)
        else $error("registers not cleared by reset");

endmodule : adccr_top

// file: sim/adccr_analog_model.sv
// Analog core stand-in: one fixed level per input and a comparator
`timescale 1ns/1ps
module adccr_analog_model
#(
    parameter int unsigned NUM_CH = 16
)
(
    input wire logic clock_i,
    input wire logic power_on_i,
    input wire logic [NUM_CH-1:0] sel_i,
    input wire logic [9:0] trial_i,
    output logic comp_o
);
    int ch;

    function automatic logic [9:0] level(input int c);
        level = 10'(c * 32'h0000_003d + 32'h0000_0007);
    endfunction : level

    initial comp_o = 1'b0;

    // Comparator registered once, then synchronised inside the block
    always @(posedge clock_i)
    begin
        ch = -1;
        for (int i = 0; i < NUM_CH; i++)
            if (sel_i[i] === 1'b1)
                ch = (ch == -1) ? i : -2;
        if (power_on_i === 1'b1 && ch >= 0)
            comp_o <= (level(ch) >= trial_i);
        else
            comp_o <= ~comp_o; // No input connected: level wanders
    end
endmodule : adccr_analog_model

// file: sim/adccr_top_tb.sv
// Self-checking bench for the converter control and result registers
`timescale 1ns/1ps
module adccr_top_tb;
    import adccr_pkg::*;
    localparam int unsigned NCH = 12;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic halt = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready, pslverr, power_on, sample, comp;
    logic [9:0] trial;
    logic [NCH-1:0] sel;
    logic [31:0] rd, lo;
    logic er;
    logic [ADDR_W-1:0] regs [3];
    int per;
    int err_count = 0;
    int samples_checked = 0;

    adccr_top #(.NUM_CH(NCH)) uut (
        .clock_i(clock_i), .srst_i(srst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .halt_i(halt),
        .comp_i(comp), .power_on_o(power_on), .sample_o(sample),
        .trial_o(trial), .ain_sel_o(sel));

    adccr_analog_model #(.NUM_CH(NCH)) analog (
        .clock_i(clock_i), .power_on_i(power_on), .sel_i(sel),
        .trial_i(trial), .comp_o(comp));

    always #10 clock_i = ~clock_i;

    function automatic logic [9:0] level(input int c);
        level = 10'(c * 32'h0000_003d + 32'h0000_0007);
    endfunction : level

    task end_sim;
        if (err_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h",
                $time, seen, exp);
        end
    endtask : check

    task timeout;
        check(32'h0000_0001, 32'h0000_0000);
        end_sim();
    endtask : timeout

    // One APB transfer, then one idle cycle
    task xfer(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            timeout();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock_i);
    endtask : xfer

    // Software polls the done flag
    task wait_done;
        int n;
        n = 0;
        do
        begin
            xfer(1'b0, ADDR_CSR, 32'h0000_0000);
            n++;
        end while (rd[7] !== 1'b1 && n < 300);
        if (n >= 300)
            timeout();
    endtask : wait_done

    // Clocks from the previous sampling start to the next one
    task rise(output int c);
        logic p;
        c = 0;
        do
        begin
            p = sample;
            @(posedge clock_i);
            c++;
        end while (!(sample === 1'b1 && p === 1'b0) && c < 1000);
        if (c >= 1000)
            timeout();
    endtask : rise

    initial
    begin
        regs = '{ADDR_CSR, ADDR_RDH, ADDR_RDL};
        repeat (5) @(posedge clock_i);
        srst_i <= 1'b0;
        @(posedge clock_i);
        check(power_on, 1'b0);
        check(sel, '0);
        check(trial, 10'h000);
        for (int i = 0; i < 3; i++)
        begin
            xfer(1'b0, regs[i], 32'h0000_0000);
            check(rd, 32'h0000_0000);
            check(er, 1'b0);
        end
        xfer(1'b1, ADDR_CSR, 32'h0000_00cf);
        xfer(1'b0, ADDR_CSR, 32'h0000_0000);
        check(rd, 32'h0000_004f);
        check(power_on, 1'b0);
        check(sel, '0);
        pstrb <= 4'h0;
        xfer(1'b1, ADDR_CSR, 32'h0000_0020);
        pstrb <= 4'hf;
        xfer(1'b0, ADDR_CSR, 32'h0000_0000);
        check(rd, 32'h0000_004f);
        xfer(1'b0, 12'h1cc, 32'h0000_0000);
        check(er, 1'b1);
        check(rd, 32'h0000_0000);
        // Each write of a new input after the first aborts the conversion running on the last input; the repeated input 3 write does not
        for (int c = 0; c < 16; c++)
        begin
            xfer(1'b1, ADDR_CSR, 32'h0000_0020 | c);
            check(sel, (c < NCH) ? (32'h1 << c) : 32'h0);
            check(power_on, 1'b1);
            wait_done();
            if (c == 3)
            begin
                xfer(1'b1, ADDR_CSR, 32'h0000_0023);
                xfer(1'b0, ADDR_CSR, 32'h0000_0000);
                check(rd, 32'h0000_0023);
                wait_done();
            end
            xfer(1'b0, ADDR_RDL, 32'h0000_0000);
            lo = rd;
            xfer(1'b0, ADDR_RDH, 32'h0000_0000);
            if (c < NCH)
            begin
                check(lo, 32'(level(c) & 10'h003));
                check(rd, 32'(level(c) >> 2));
            end
            xfer(1'b0, ADDR_CSR, 32'h0000_0000);
            check(rd, 32'h0000_0020 | c);
        end
        xfer(1'b1, ADDR_CSR, 32'h0000_0021);
        wait_done();
        xfer(1'b1, ADDR_RDH, 32'h0000_00ff);
        xfer(1'b0, ADDR_RDH, 32'h0000_0000);
        check(rd, 32'(level(1) >> 2));
        rise(per);
        rise(per);
        rise(per);
        check(per, CONV_TICKS * DIV_SLOW);
        xfer(1'b1, ADDR_CSR, 32'h0000_0061);
        rise(per);
        rise(per);
        rise(per);
        check(per, CONV_TICKS * DIV_FAST);
        halt <= 1'b1;
        repeat (2) @(posedge clock_i);
        check(power_on, 1'b0);
        xfer(1'b1, ADDR_CSR, 32'h0000_0021);
        repeat (200) @(posedge clock_i);
        xfer(1'b0, ADDR_CSR, 32'h0000_0000);
        check(rd, 32'h0000_0021);
        check(sample, 1'b0);
        halt <= 1'b0;
        wait_done();
        xfer(1'b1, ADDR_CSR, 32'h0000_0000);
        check(power_on, 1'b0);
        repeat (200) @(posedge clock_i);
        xfer(1'b0, ADDR_CSR, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        check(sel, '0);
        check(sample, 1'b0);
        check(trial, 10'h000);
        end_sim();
    end
endmodule : adccr_top_tb
